// *** src/nand_ecc_pkg.sv ***
// Shared constants for the internal correction and page layout block.
package nand_ecc_pkg;
	// Page geometry: four user sectors, each with one spare slice.
	localparam int MAIN_BYTES   = 2048;
	localparam int SECTOR_BYTES = 512;
	localparam int SPARE_BYTES  = 128;
	localparam int SLICE_BYTES  = 32;
	localparam int FREE_META    = 4;
	// Correction strength selector, index into the strength table.
	localparam logic [2:0] STR_0 = 3'h0;
	localparam logic [2:0] STR_14 = 3'h5;
	// Array operation times in their own units and the clock rate.
	localparam int  CLK_MHZ      = 50;
	localparam int  T_INIT_US    = 10;
	localparam int  T_READ_US    = 150;
	localparam int  T_PROG_US    = 600;
	localparam real T_ERASE_MS   = 2.5;
	localparam int  INIT_CYC     = T_INIT_US * CLK_MHZ;
	localparam int  READ_CYC     = T_READ_US * CLK_MHZ;
	localparam int  PROG_CYC     = T_PROG_US * CLK_MHZ;
	localparam int  ERASE_CYC    = int'(T_ERASE_MS * 1000.0 * CLK_MHZ);
	// Link commands and feature addresses.
	localparam logic [7:0] CMD_SET_FEATURE = 8'h1f;
	localparam logic [7:0] CMD_READ_SETTING_CMD = 8'h0f;
	localparam logic [7:0] FEAT_STATUS     = 8'hc0;
	localparam logic [7:0] FEAT_CONFIG     = 8'hb0;
	localparam int         CFG_ECC_EN_BIT  = 4;
	// Register offsets (byte addresses).
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_OP     = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_ST = 8'h0c;
	localparam logic [7:0] REG_IRQ_MK = 8'h10;
	// Control register fields and reset values.
	localparam int CTRL_ECC_EN   = 0;
	localparam int CTRL_ALL_META = 1;
	localparam int CTRL_STR_LSB  = 2;
	localparam logic CTRL_ECC_EN_RST = 1'b1;
	// Operation codes written to the operation register.
	localparam logic [1:0] OP_READ  = 2'h1;
	localparam logic [1:0] OP_PROG  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	// Status byte fields.
	localparam int ST_BUSY = 0;
	localparam int ST_PFAIL = 2;
	localparam int ST_EFAIL = 3;
	localparam int ST_RES_LSB = 4;
	// Correction result codes.
	localparam logic [1:0] RES_CLEAN = 2'h0;
	localparam logic [1:0] RES_FIXED = 2'h1;
	localparam logic [1:0] RES_FAIL  = 2'h2;
	localparam logic [1:0] RES_MAX   = 2'h3;
	// Interrupt bits.
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_UNCORR = 2;
	// Signature feedback polynomial.
	localparam logic [31:0] SIG_POLY = 32'h04c11db7;
endpackage

// *** src/sector_layout.sv ***
// Column classifier: sector, correction coverage and parity slot of one byte.
`timescale 1ns/1ns
`default_nettype none
module sector_layout
	import nand_ecc_pkg::*;
(
	input  wire logic [11:0] col,
	input  wire logic [2:0]  strength,
	input  wire logic        all_meta,
	output logic      [1:0]  sector,
	output logic             covered,
	output logic             parity_slot,
	output logic      [4:0]  parity_idx
);
	logic [5:0] meta_len; // Metadata bytes per slice at this strength.
	logic [6:0] off;      // Offset into the spare area.
	logic [4:0] b;        // Offset into one slice.

	// Metadata length shrinks as parity grows with strength.
	always_comb begin
		case (strength)
			3'h0: meta_len = 6'd32;
			3'h1: meta_len = 6'd28;
			3'h2: meta_len = 6'd24;
			3'h3: meta_len = 6'd22;
			3'h4: meta_len = 6'd18;
			default: meta_len = 6'd8;
		endcase
	end

	// Main bytes map by address bits; spare bytes by their slice.
	always_comb begin
		off = col[6:0];
		b = off[4:0];
		parity_idx = 5'h0;
		if (col < 12'(MAIN_BYTES)) begin // R4
			sector = col[10:9];
			covered = 1'b1;
			parity_slot = 1'b0;
		end else if (col < 12'(MAIN_BYTES + SPARE_BYTES)) begin
			sector = off[6:5];
			parity_slot = ({1'b0, b} >= meta_len); // R5
			parity_idx = 5'(b - meta_len[4:0]);
			// Leading metadata bytes stay open unless full cover is chosen.
			covered = !parity_slot && (all_meta || b >= 5'(FREE_META)); // R7 R8
		end else begin
			sector = 2'h0;
			covered = 1'b0;
			parity_slot = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** src/feature_link.sv ***
// Serial feature port: get and set feature over the host-clocked link.
`timescale 1ns/1ns
`default_nettype none
module feature_link
	import nand_ecc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       si,
	output logic            so,
	output logic            so_oe,
	input  wire logic [7:0] status_byte,
	input  wire logic [7:0] config_byte,
	output logic            set_pulse,
	output logic      [7:0] set_addr,
	output logic      [7:0] set_data
);
	logic [2:0] sclk_s_r, cs_s_r, si_s_r; // Two sync stages plus history.
	logic [7:0] shift_r;                  // Incoming bits.
	logic [2:0] bit_r;                    // Bit count in byte.
	logic [1:0] byte_r;                   // Byte count in frame.
	logic [7:0] cmd_r;                    // First byte of the frame.
	logic [7:0] out_r;                    // Outgoing bits.
	logic       rise, fall, sel;
	logic [7:0] byte_in;

	// Bit 0 is the first stage and only bit 1 reads it; bit 2 keeps history for edges.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s_r <= 3'h0;
			cs_s_r <= 3'h7;
			si_s_r <= 3'h0;
		end else if (ce) begin
			sclk_s_r <= {sclk_s_r[1:0], sclk};
			cs_s_r <= {cs_s_r[1:0], cs_n};
			si_s_r <= {si_s_r[1:0], si};
		end
	end
	assign sel = !cs_s_r[1];
	assign rise = sel && sclk_s_r[1] && !sclk_s_r[2];
	assign fall = sel && !sclk_s_r[1] && sclk_s_r[2];
	assign byte_in = {shift_r[6:0], si_s_r[1]};

	// Input side: bytes assemble on rising edges, mode 0 framing.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= 8'h0;
			bit_r <= 3'h0;
			byte_r <= 2'h0;
			cmd_r <= 8'h0;
			set_addr <= 8'h0;
			set_data <= 8'h0;
			set_pulse <= 1'b0;
		end else if (ce) begin
			set_pulse <= 1'b0;
			if (!sel) begin
				bit_r <= 3'h0;
				byte_r <= 2'h0;
			end else if (rise) begin
				shift_r <= byte_in;
				bit_r <= bit_r + 3'h1;
				if (bit_r == 3'h7) begin
					if (byte_r != 2'h3)
						byte_r <= byte_r + 2'h1;
					if (byte_r == 2'h0)
						cmd_r <= byte_in;
					if (byte_r == 2'h1)
						set_addr <= byte_in;
					// A set feature frame commits on its data byte.
					if (byte_r == 2'h2 && cmd_r == CMD_SET_FEATURE) begin // R2
						set_data <= byte_in;
						set_pulse <= 1'b1;
					end
				end
			end
		end
	end

	// Output side: the addressed feature shifts out on falling edges.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= 8'h0;
			so <= 1'b0;
		end else if (ce) begin
			if (rise && bit_r == 3'h7 && byte_r != 2'h0 && cmd_r == CMD_READ_SETTING_CMD) begin
				// Byte 1 is the address; reads repeat, so polling needs no new frame.
				if ((byte_r == 2'h1 ? byte_in : set_addr) == FEAT_STATUS) // R17
					out_r <= status_byte;
				else if ((byte_r == 2'h1 ? byte_in : set_addr) == FEAT_CONFIG)
					out_r <= config_byte;
				else
					out_r <= 8'h0;
			end else if (fall) begin
				so <= out_r[7];
				out_r <= {out_r[6:0], 1'b0};
			end
		end
	end
	assign so_oe = sel;
endmodule
`default_nettype wire

// *** src/nand_ecc_page.sv ***
// Correction engine, page layout, operation timing and registers of the flash.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: Correction is on straight after power-up.
// R2: Feature bit enables or disables correction.
// R3: Host parity bytes dropped while correction on.
// R4: Page is four 512-byte sectors plus spare.
// R5: Strength 0..14 bits sets metadata/parity split.
// R6: Default strength is fourteen bits per sector.
// R7: First four metadata bytes left unprotected.
// R8: Option covers every metadata byte.
// R9: Zero marker word means bad block.
// R10: Host never programs or erases bad blocks.
// R11: Operations on bad blocks are aborted.
// R12: Busy high during power-on initialization.
// R13: Host polls status until busy clears.
// R14: Page load busy at least 120 us.
// R15: Program 600 us, erase 2.5 ms, busy.
// R16: Result code 00/01/10/11 as defined.
// R17: Status read by read_setting_cmd at C0.
// R18: Each sector encoded and checked alone.
module nand_ecc_page
	import nand_ecc_pkg::*;
#(
	parameter int READ_CYCLES  = READ_CYC,
	parameter int PROG_CYCLES  = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        si,
	output logic             so,
	output logic             so_oe,
	input  wire logic [15:0] marker_word,
	input  wire logic        cache_valid,
	input  wire logic [11:0] cache_col,
	input  wire logic [7:0]  cache_byte,
	input  wire logic [3:0]  fixed_bits,
	output logic             busy,
	output logic             par_valid,
	output logic             par_drop,
	output logic      [11:0] par_col,
	output logic      [7:0]  par_byte
);
	typedef enum logic [2:0] {INIT, IDLE, READ, PROG, ERASE} op_state_type;

	op_state_type state_r;        // Array operation in progress.
	logic [16:0]  timer_r;        // Remaining cycles of the operation.
	logic         ecc_en_r;       // Correction enable.
	logic         all_meta_r;     // Cover every metadata byte.
	logic [2:0]   strength_r;     // Strength table index.
	logic [1:0]   result_r;       // Correction result of the last load.
	logic         pfail_r;        // Program aborted.
	logic         efail_r;        // Erase aborted.
	logic [2:0]   irq_st_r;       // Sticky events.
	logic [2:0]   irq_mk_r;       // Event mask.
	logic [3:0]   mismatch_r;     // Per-sector check failure.
	logic [31:0]  sig_r [4];      // Per-sector running signature.
	logic [2:0]   irq_set;
	logic [7:0]   status_byte;
	logic [7:0]   config_byte;
	logic         set_pulse;
	logic [7:0]   set_addr, set_data;
	logic [1:0]   sector;
	logic         covered, parity_slot;
	logic [4:0]   parity_idx;
	logic         op_wr, start_ok, bad_blk, load_end;
	logic [3:0]   max_bits;
	logic [7:0]   expect_byte;

	// Link side of the feature access.
	feature_link u_link (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.ce          (ce),
		.sclk        (sclk),
		.cs_n        (cs_n),
		.si          (si),
		.so          (so),
		.so_oe       (so_oe),
		.status_byte (status_byte),
		.config_byte (config_byte),
		.set_pulse   (set_pulse),
		.set_addr    (set_addr),
		.set_data    (set_data)
	);

	// Classifies each byte on the cache stream.
	sector_layout u_layout (
		.col         (cache_col),
		.strength    (strength_r),
		.all_meta    (all_meta_r),
		.sector      (sector),
		.covered     (covered),
		.parity_slot (parity_slot),
		.parity_idx  (parity_idx)
	);

	assign busy = (state_r != IDLE); // R12 R14 R15
	assign status_byte = {2'h0, result_r, efail_r, pfail_r, 1'b0, busy};
	assign config_byte = 8'(ecc_en_r) << CFG_ECC_EN_BIT;
	assign op_wr = reg_wr && reg_addr == REG_OP;
	assign bad_blk = (marker_word == 16'h0); // R9
	assign start_ok = op_wr && state_r == IDLE && reg_wdata[1:0] != 2'h0;
	assign load_end = state_r == READ && timer_r == 17'h1;
	assign expect_byte = sig_r[sector][8 * parity_idx[1:0] +: 8];

	// Largest count the current strength still corrects.
	always_comb begin
		case (strength_r)
			3'h0: max_bits = 4'd0;
			3'h1: max_bits = 4'd2;
			3'h2: max_bits = 4'd4;
			3'h3: max_bits = 4'd6;
			3'h4: max_bits = 4'd8;
			default: max_bits = 4'd14;
		endcase
	end

	// Configuration; ignored while initializing so defaults hold until ready.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ecc_en_r <= CTRL_ECC_EN_RST; // R1
			all_meta_r <= 1'b0;          // R7
			strength_r <= STR_14;        // R6
		end else if (ce && state_r != INIT) begin
			if (reg_wr && reg_addr == REG_CTRL) begin
				ecc_en_r <= reg_wdata[CTRL_ECC_EN]; // R2
				all_meta_r <= reg_wdata[CTRL_ALL_META]; // R8
				if (reg_wdata[CTRL_STR_LSB +: 3] <= STR_14)
					strength_r <= reg_wdata[CTRL_STR_LSB +: 3]; // R5
			end else if (set_pulse && set_addr == FEAT_CONFIG) begin
				ecc_en_r <= set_data[CFG_ECC_EN_BIT]; // R2
			end
		end
	end

	// Operation sequencer; a bad block never reaches the array.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= INIT;
			timer_r <= 17'(INIT_CYC);
		end else if (ce) begin
			case (state_r)
				INIT, READ, PROG, ERASE: begin
					timer_r <= timer_r - 17'h1;
					if (timer_r == 17'h1)
						state_r <= IDLE; // R12
				end
				default: begin
					if (start_ok && !bad_blk) begin
						case (reg_wdata[1:0])
							OP_READ: begin
								state_r <= READ;
								timer_r <= 17'(READ_CYCLES); // R14
							end
							OP_PROG: begin
								state_r <= PROG;
								timer_r <= 17'(PROG_CYCLES); // R15
							end
							default: begin
								state_r <= ERASE;
								timer_r <= 17'(ERASE_CYCLES); // R15
							end
						endcase
					end
				end
			endcase
		end
	end

	// Abort flags; each clears when the next operation of its kind starts.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pfail_r <= 1'b0;
			efail_r <= 1'b0;
		end else if (ce && start_ok) begin
			if (reg_wdata[1:0] == OP_PROG)
				pfail_r <= bad_blk; // R11
			if (reg_wdata[1:0] == OP_ERASE)
				efail_r <= bad_blk; // R11
		end
	end

	// Per-sector signatures: each sector sees only its own covered bytes.
	for (genvar s = 0; s < 4; s++) begin : g_sector
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				sig_r[s] <= 32'h0;
				mismatch_r[s] <= 1'b0;
			end else if (ce) begin
				if (start_ok) begin
					sig_r[s] <= 32'h0;
					mismatch_r[s] <= 1'b0;
				end else if (cache_valid && ecc_en_r && sector == 2'(s)) begin // R18
					if (covered)
						sig_r[s] <= {sig_r[s][30:0], 1'b0}
							^ (sig_r[s][31] ? SIG_POLY : 32'h0)
							^ {24'h0, cache_byte};
					else if (parity_slot && state_r == READ && cache_byte != expect_byte)
						mismatch_r[s] <= 1'b1; // R18
				end
			end
		end
	end

	// Generated parity and the drop strobe for host parity bytes.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			par_valid <= 1'b0;
			par_drop <= 1'b0;
			par_col <= 12'h0;
			par_byte <= 8'h0;
		end else if (ce) begin
			par_valid <= cache_valid && state_r == PROG;
			par_drop <= cache_valid && state_r == PROG && ecc_en_r && parity_slot; // R3
			par_col <= cache_col;
			par_byte <= expect_byte;
		end
	end

	// Correction result: cleared at load start, set when the load ends.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result_r <= RES_CLEAN;
		end else if (ce) begin
			if (start_ok && reg_wdata[1:0] == OP_READ)
				result_r <= RES_CLEAN;
			else if (load_end) begin
				if (!ecc_en_r || strength_r == STR_0)
					result_r <= RES_CLEAN; // R2
				else if (mismatch_r != 4'h0 || fixed_bits > max_bits)
					result_r <= RES_FAIL; // R16
				else if (fixed_bits == 4'h0)
					result_r <= RES_CLEAN; // R16
				else if (fixed_bits == max_bits)
					result_r <= RES_MAX; // R16
				else
					result_r <= RES_FIXED; // R16
			end
		end
	end

	// Events: operation end, abort, and an uncorrectable load.
	always_comb begin
		irq_set = 3'h0;
		irq_set[IRQ_DONE] = state_r inside {READ, PROG, ERASE} && timer_r == 17'h1;
		irq_set[IRQ_ABORT] = start_ok && bad_blk;
		irq_set[IRQ_UNCORR] = load_end && ecc_en_r && strength_r != STR_0
			&& (mismatch_r != 4'h0 || fixed_bits > max_bits);
	end

	// Sticky status, write one to clear; a new event beats the clear.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_st_r <= 3'h0;
			irq_mk_r <= 3'h0;
		end else if (ce) begin
			if (reg_wr && reg_addr == REG_IRQ_ST)
				irq_st_r <= (irq_st_r & ~reg_wdata[2:0]) | irq_set;
			else
				irq_st_r <= irq_st_r | irq_set;
			if (reg_wr && reg_addr == REG_IRQ_MK)
				irq_mk_r <= reg_wdata[2:0];
		end
	end
	assign irq = |(irq_st_r & irq_mk_r);

	// Read port: data stands one cycle after the strobe; holes read zero.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0;
		end else if (ce) begin
			if (!reg_rd)
				reg_rdata <= 32'h0;
			else if (reg_addr == REG_CTRL)
				reg_rdata <= {27'h0, strength_r, all_meta_r, ecc_en_r};
			else if (reg_addr == REG_STATUS)
				reg_rdata <= {24'h0, status_byte};
			else if (reg_addr == REG_IRQ_ST)
				reg_rdata <= {29'h0, irq_st_r};
			else if (reg_addr == REG_IRQ_MK)
				reg_rdata <= {29'h0, irq_mk_r};
			else
				reg_rdata <= 32'h0;
		end
	end

	// Checks: cycles spent in the current operation.
	logic [16:0] elapsed_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			elapsed_r <= 17'h0;
		else if (ce)
			elapsed_r <= (state_r == IDLE) ? 17'h0 : elapsed_r + 17'h1;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	init_busy_a: assert property (state_r == INIT |-> status_byte[ST_BUSY]) // R12
		else $error("busy clear during initialization");
	init_cfg_a: assert property (state_r == INIT |-> ecc_en_r && strength_r == STR_14) // R1
		else $error("defaults not held during initialization");
	read_time_a: assert property ($fell(state_r == READ) && ce |-> $past(elapsed_r) >= 17'(READ_CYCLES - 1)) // R14
		else $error("page load ended early");
	prog_busy_a: assert property (start_ok && !bad_blk && reg_wdata[1:0] == OP_PROG && ce |=> busy [*8]) // R15
		else $error("program not busy");
	abort_a: assert property (start_ok && bad_blk && ce |=> state_r == IDLE && irq_st_r[IRQ_ABORT]) // R11
		else $error("bad block operation not aborted");
	drop_a: assert property (par_drop |-> par_valid && $past(ecc_en_r)) // R3
		else $error("parity dropped with correction off");
	fail_res_a: assert property (load_end && ce && ecc_en_r && strength_r != STR_0 && mismatch_r != 4'h0 |=> result_r == RES_FAIL) // R16
		else $error("mismatch not reported");
	off_res_a: assert property (load_end && ce && !ecc_en_r |=> result_r == RES_CLEAN) // R2
		else $error("result set with correction off");
	layout_a: assert property (cache_valid && cache_col < 12'(MAIN_BYTES) |-> sector == cache_col[10:9] && covered) // R4
		else $error("main byte misclassified");

	load_c: cover property (load_end ##1 result_r == RES_FIXED);
	prog_c: cover property (par_drop);
	abort_c: cover property (start_ok && bad_blk);
	set_c: cover property (set_pulse && set_addr == FEAT_CONFIG);
endmodule
`default_nettype wire

// *** verification/link_host.sv ***
// Host-side serial link model that issues feature reads and writes.
`timescale 1ns/1ns
`default_nettype none
module link_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	// The clock stands low and the select high between frames.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// One frame of command, address and data bits, most significant bit first.
	// The reply bit is taken late in each high phase, so the sampled path has time.
	task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		logic [23:0] w;
		w = {c, a, d};
		r = 8'h00;
		#7 cs_n = 1'b0;
		#80;
		for (int i = 23; i >= 0; i--) begin
			si = w[i];
			#80 sclk = 1'b1;
			#70 r = {r[6:0], so};
			#10 sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		// A released line shows the inverse of its last bit, never a held value.
		si = ~si;
		#200;
	endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the flash correction, timing and register block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import nand_ecc_pkg::*;
	// Short operation counts keep the run brief.
	localparam int RD_N = 20;
	localparam int PG_N = 30;
	localparam int ER_N = 40;
	logic        mclk;
	logic        rst_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        sclk;
	logic        cs_n;
	logic        si;
	logic        so;
	logic        so_oe;
	logic [15:0] marker_word;
	logic        cache_valid;
	logic [11:0] cache_col;
	logic        ce;
	logic [3:0]  fixed_bits;
	logic        busy;
	logic        par_valid;
	logic        par_drop;
	logic [11:0] par_col;
	logic [7:0]  par_byte;
	logic [31:0] d;
	logic [7:0]  r;
	int          n;
	int          num_errors = 0;
	int          tests_run = 0;
	// Metadata length of one spare slice for each strength setting.
	int          meta [6] = '{32, 28, 24, 22, 18, 8};
	nand_ecc_page #(.READ_CYCLES(RD_N), .PROG_CYCLES(PG_N), .ERASE_CYCLES(ER_N)) uut (
		.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
		.marker_word(marker_word), .cache_valid(cache_valid), .cache_col(cache_col),
		.cache_byte(8'h5a), .fixed_bits(fixed_bits), .busy(busy), .par_valid(par_valid),
		.par_drop(par_drop), .par_col(par_col), .par_byte(par_byte));
	link_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
	// Free-running system clock.
	initial mclk = 1'b0;
	always #10 mclk = ~mclk;
	// Compare one value and count it.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle register read; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Count the cycles that busy stays high, bounded.
	task automatic wait_idle(output int c);
		#1 c = 0;
		while (busy === 1'b1 && c < 200) begin
			@(posedge mclk);
			#1 c++;
		end
	endtask
	// Send one cache byte; check the parity strobes and column one cycle later.
	task automatic byte_drop(input logic [11:0] col, input logic [1:0] exp);
		@(posedge mclk);
		cache_col <= col;
		cache_valid <= 1'b1;
		@(posedge mclk);
		cache_valid <= 1'b0;
		#1 chk({18'h0, par_valid, par_drop, par_col}, {18'h0, exp, col});
	endtask
	// Print the verdict and stop.
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// A hang counts as a failure.
	initial begin
		#1000000;
		num_errors++;
		end_of_test();
	end
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cache_valid = 1'b0;
		cache_col = 12'h000;
		marker_word = 16'h1234;
		ce = 1'b1;
		fixed_bits = 4'h3;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk(busy, 1'b1);
		// Settings written while initializing must not take hold.
		wr(REG_CTRL, 32'h0);
		host.xfer(CMD_READ_SETTING_CMD, FEAT_STATUS, 8'h00, r);
		chk(r[ST_BUSY], 1'b1);
		n = 0;
		// The host keeps polling status until the device is ready.
		while (r[ST_BUSY] !== 1'b0 && n < 8) begin
			host.xfer(CMD_READ_SETTING_CMD, FEAT_STATUS, 8'h00, r);
			n++;
		end
		chk(r[ST_BUSY], 1'b0);
		rd(REG_CTRL, d);
		chk(d, 32'h15);
		// The output enable follows the select, high in mid-frame only.
		fork
			host.xfer(CMD_READ_SETTING_CMD, FEAT_CONFIG, 8'h00, r);
			#2000 chk(so_oe, 1'b1);
		join
		chk(so_oe, 1'b0);
		chk(r[CFG_ECC_EN_BIT], 1'b1);
		host.xfer(CMD_SET_FEATURE, FEAT_CONFIG, 8'h00, r);
		rd(REG_CTRL, d);
		chk(d, 32'h14);
		// With correction off a parity column passes through untouched.
		wr(REG_OP, {30'h0, OP_PROG});
		byte_drop(12'd2056, 2'h2);
		wait_idle(n);
		// With correction off a load reports clean whatever the array counted.
		wr(REG_OP, {30'h0, OP_READ});
		wait_idle(n);
		rd(REG_STATUS, d);
		chk(d[ST_RES_LSB +: 2], RES_CLEAN);
		// Walk every strength: the slice boundary moves with the split.
		for (int s = 0; s < 6; s++) begin
			wr(REG_CTRL, 32'(s * 4 + 1));
			wr(REG_OP, {30'h0, OP_PROG});
			byte_drop(12'd100, 2'h2);
			byte_drop(12'(2144 + meta[s] - 1), 2'h2);
			// One covered byte into a cleared signature becomes parity byte 0.
			if (s != 0) begin
				byte_drop(12'(2144 + meta[s]), 2'h3);
				chk(par_byte, 8'h5a);
			end
			wait_idle(n);
		end
		// Busy length of each array operation.
		wr(REG_OP, {30'h0, OP_READ});
		wait_idle(n);
		chk(n, RD_N);
		rd(REG_STATUS, d);
		chk(d[ST_RES_LSB +: 2], RES_FIXED);
		// Fourteen corrected bits is the limit of the strongest setting.
		fixed_bits <= 4'he;
		wr(REG_OP, {30'h0, OP_READ});
		wait_idle(n);
		rd(REG_STATUS, d);
		chk(d[ST_RES_LSB +: 2], RES_MAX);
		// A parity byte that disagrees with its sector signature is uncorrectable.
		fixed_bits <= 4'h0;
		wr(REG_OP, {30'h0, OP_READ});
		byte_drop(12'd2152, 2'h0);
		wait_idle(n);
		rd(REG_STATUS, d);
		chk(d[ST_RES_LSB +: 2], RES_FAIL);
		wr(REG_OP, {30'h0, OP_PROG});
		wait_idle(n);
		chk(n, PG_N);
		wr(REG_OP, {30'h0, OP_ERASE});
		// Frozen cycles stretch the erase, so the full count still follows them.
		ce <= 1'b0;
		repeat (5) @(posedge mclk);
		ce <= 1'b1;
		wait_idle(n);
		chk(n, ER_N);
		rd(REG_STATUS, d);
		chk(d[ST_BUSY], 1'b0);
		// Completion is sticky but held back by the mask.
		wr(REG_IRQ_MK, 32'h0);
		#1 chk(irq, 1'b0);
		rd(REG_IRQ_ST, d);
		chk(d[IRQ_DONE], 1'b1);
		chk(d[IRQ_UNCORR], 1'b1);
		wr(REG_IRQ_ST, 32'h7);
		wr(REG_IRQ_MK, 32'h2);
		// A zero marker word marks the block bad, so the operation aborts.
		marker_word <= 16'h0000;
		wr(REG_OP, {30'h0, OP_PROG});
		#1 chk(busy, 1'b0);
		rd(REG_STATUS, d);
		chk(d[ST_PFAIL], 1'b1);
		chk(irq, 1'b1);
		wr(REG_OP, {30'h0, OP_ERASE});
		rd(REG_STATUS, d);
		chk(d[ST_EFAIL], 1'b1);
		wr(REG_IRQ_ST, 32'h7);
		#1 chk(irq, 1'b0);
		rd(8'h20, d);
		chk(d, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
